// ### src/alarm_interval_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

// Compares the fields chosen by the interval code; registered result
module alarm_interval_match
    import alarm_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [3:0] interval,
    input wire alarm_pkg::cal_time_t now,
    input wire alarm_pkg::cal_time_t alarm,
    output logic hit
);
    import alarm_pkg::*;

    logic hit_nxt;

    // Field compare under the implemented mask
    function automatic logic same(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
        return (a & m) == (b & m);
    endfunction

    // Interval decode into matched fields
    always_comb begin
        logic s_u;
        logic s_all;
        logic m_all;
        logic h_all;
        logic d_all;
        s_u = (now.second[3:0] == alarm.second[3:0]);
        s_all = same(now.second, alarm.second, `MASK_SECOND);
        m_all = same(now.minute, alarm.minute, `MASK_MINUTE);
        h_all = same(now.hour, alarm.hour, `MASK_HOUR);
        d_all = same(now.day, alarm.day, `MASK_DAY);
        case (interval)
            `IVL_HALFSEC: hit_nxt = 1'b1;
            `IVL_SECOND: hit_nxt = 1'b1;
            `IVL_TENSEC: hit_nxt = s_u;
            `IVL_MINUTE: hit_nxt = s_all;
            `IVL_TENMIN: hit_nxt = s_all && (now.minute[3:0] == alarm.minute[3:0]);
            `IVL_HOUR: hit_nxt = s_all && m_all;
            `IVL_DAY: hit_nxt = s_all && m_all && h_all;
            `IVL_WEEK: hit_nxt = s_all && m_all && h_all && same(now.weekday, alarm.weekday, `MASK_WEEKDAY);
            `IVL_MONTH: hit_nxt = s_all && m_all && h_all && d_all;
            `IVL_YEAR: hit_nxt = s_all && m_all && h_all && d_all && same(now.month, alarm.month, `MASK_MONTH);
            default: hit_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hit <= 1'b0;
        end else begin
            hit <= hit_nxt;
        end
    end
endmodule

`default_nettype wire

// ### src/alarm_params.svh
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH

// Register word offsets (byte address = index * 4)
`define OFS_CONTROL 4'h0
`define OFS_REPEAT 4'h1
`define OFS_MONTH 4'h2
`define OFS_WEEKDAY 4'h3
`define OFS_DAY 4'h4
`define OFS_HOUR 4'h5
`define OFS_MINUTE 4'h6
`define OFS_SECOND 4'h7
`define OFS_STATUS 4'h8

// Implemented bit masks of each value register
`define MASK_MONTH 8'h1f
`define MASK_WEEKDAY 8'h07
`define MASK_DAY 8'h3f
`define MASK_HOUR 8'h3f
`define MASK_MINUTE 8'h7f
`define MASK_SECOND 8'h7f

// Storage slot of each value register, none for other words
`define SLOT_SECOND 4'h0
`define SLOT_MINUTE 4'h1
`define SLOT_HOUR 4'h2
`define SLOT_DAY 4'h3
`define SLOT_WEEKDAY 4'h4
`define SLOT_MONTH 4'h5
`define SLOT_NONE 4'hf

// Control field positions
`define CTL_ENABLE 7
`define CTL_CHIME 6
`define CTL_MASK_HI 5
`define CTL_MASK_LO 2

// Interval codes
`define IVL_HALFSEC 4'h0
`define IVL_SECOND 4'h1
`define IVL_TENSEC 4'h2
`define IVL_MINUTE 4'h3
`define IVL_TENMIN 4'h4
`define IVL_HOUR 4'h5
`define IVL_DAY 4'h6
`define IVL_WEEK 4'h7
`define IVL_MONTH 4'h8
`define IVL_YEAR 4'h9

// Reset values and misc
`define CTL_RESET 8'h00
`define RPT_RESET 8'h00
`define RPT_ZERO 8'h00
`define RPT_ONE 8'h01
`define DATA_ZERO 32'h0000_0000
`define BYTE_ZERO 8'h00
`define DEAD_READ 32'hdead_beef

`endif

// ### src/alarm_pkg.sv
package alarm_pkg;
    // Current calendar time, all BCD
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] weekday;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } cal_time_t;

    // Avalon-MM slave request
    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avm_req_t;

    // Avalon-MM slave answer
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avm_rsp_t;
endpackage

// ### src/alarm_value_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

// Small storage for the six BCD alarm values, no reset on contents
module alarm_value_mem (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [47:0] all_values
);
    logic [7:0] mem [0:5];

    // Write port, contents undefined until software writes
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clock) begin
        rd_data <= mem[rd_idx];
    end

    // Flat view for the comparator
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_flat
            assign all_values[8*g +: 8] = mem[g];
        end
    endgenerate
endmodule

`default_nettype wire

// ### src/calendar_alarm_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

module calendar_alarm_match
    import alarm_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire alarm_pkg::cal_time_t now,
    input wire logic tick_half,
    input wire logic tick_second,
    output logic alarm_event
);
    import alarm_pkg::*;

    // ----------------------------------------
    // Registers and wires
    // ----------------------------------------
    logic [7:0] control_r;
    logic [7:0] control_nxt;
    logic [7:0] repeat_r;
    logic [7:0] repeat_nxt;
    logic ack_r;
    logic rd_pending_r;
    logic [3:0] rd_index_r;
    logic event_r;
    logic hit;
    logic fire;
    logic [47:0] stored;
    logic [7:0] mem_rd;
    logic [7:0] wr_masked;
    logic [2:0] mem_wr_idx;
    logic mem_wr_en;
    logic [3:0] word_idx;
    logic [3:0] slot;
    logic bus_wr;
    logic bus_rd;
    cal_time_t alarm_vals;
    logic [3:0] interval;
    logic enable;
    logic chime;

    // ----------------------------------------
    // Bus decode and control fields
    // ----------------------------------------
    // Word index, request qualifiers and control fields
    assign word_idx = avs_address[5:2];
    assign bus_wr = avs_write && !ack_r;
    assign bus_rd = avs_read && !ack_r && !rd_pending_r;
    assign enable = control_r[`CTL_ENABLE];
    assign chime = control_r[`CTL_CHIME];
    assign interval = control_r[`CTL_MASK_HI:`CTL_MASK_LO];

    // Value-register index in the store, or none
    function automatic logic [3:0] value_slot(input logic [3:0] idx);
        if (idx == `OFS_MONTH) begin
            return `SLOT_MONTH;
        end else if (idx == `OFS_WEEKDAY) begin
            return `SLOT_WEEKDAY;
        end else if (idx == `OFS_DAY) begin
            return `SLOT_DAY;
        end else if (idx == `OFS_HOUR) begin
            return `SLOT_HOUR;
        end else if (idx == `OFS_MINUTE) begin
            return `SLOT_MINUTE;
        end else if (idx == `OFS_SECOND) begin
            return `SLOT_SECOND;
        end else begin
            return `SLOT_NONE;
        end
    endfunction

    // Implemented bits of each value register
    function automatic logic [7:0] value_mask(input logic [3:0] idx);
        if (idx == `OFS_MONTH) begin
            return `MASK_MONTH;
        end else if (idx == `OFS_WEEKDAY) begin
            return `MASK_WEEKDAY;
        end else if (idx == `OFS_DAY) begin
            return `MASK_DAY;
        end else if (idx == `OFS_HOUR) begin
            return `MASK_HOUR;
        end else if (idx == `OFS_MINUTE) begin
            return `MASK_MINUTE;
        end else if (idx == `OFS_SECOND) begin
            return `MASK_SECOND;
        end else begin
            return `BYTE_ZERO;
        end
    endfunction

    // ----------------------------------------
    // Alarm value storage
    // ----------------------------------------
    // field widths masked
    assign wr_masked = avs_writedata[7:0] & value_mask(word_idx);
    // Slot of the addressed value register, none for other words
    assign slot = value_slot(word_idx);
    assign mem_wr_idx = slot[2:0];
    assign mem_wr_en = bus_wr && avs_byteenable[0] && (slot != `SLOT_NONE);

    alarm_value_mem u_mem (
        .clock(clock),
        .wr_en(mem_wr_en),
        .wr_idx(mem_wr_idx),
        .wr_data(wr_masked),
        .rd_idx(mem_wr_idx),
        .rd_data(mem_rd),
        .all_values(stored)
    );

    // Slot order maps stored bytes to calendar fields
    assign alarm_vals.second = stored[7:0];
    assign alarm_vals.minute = stored[15:8];
    assign alarm_vals.hour = stored[23:16];
    assign alarm_vals.day = stored[31:24];
    assign alarm_vals.weekday = stored[39:32];
    assign alarm_vals.month = stored[47:40];

    // ----------------------------------------
    // Match and event timing
    // ----------------------------------------
    // interval field chooses compared fields
    alarm_interval_match u_match (
        .clock(clock),
        .arst_n(arst_n),
        .interval(interval),
        .now(now),
        .alarm(alarm_vals),
        .hit(hit)
    );

    // event on tick when enabled and matched
    assign fire = enable && hit && ((interval == `IVL_HALFSEC) ? tick_half : tick_second);

    // Event output, one cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            event_r <= 1'b0;
        end else begin
            event_r <= fire;
        end
    end
    assign alarm_event = event_r;

    // ----------------------------------------
    // Control and repeat counter
    // ----------------------------------------
    // Next control and counter values; an event's decrement or enable clear wins over a bus write
    always_comb begin
        control_nxt = control_r;
        repeat_nxt = repeat_r;
        if (bus_wr && avs_byteenable[0] && word_idx == `OFS_CONTROL) begin
            control_nxt = {avs_writedata[7:2], 2'b00};
        end
        if (bus_wr && avs_byteenable[0] && word_idx == `OFS_REPEAT) begin
            repeat_nxt = avs_writedata[7:0];
        end
        if (fire) begin
            if (repeat_r != `RPT_ZERO || chime) begin
                repeat_nxt = repeat_r - `RPT_ONE;
            end
            if (repeat_r == `RPT_ZERO && !chime) begin
                control_nxt[`CTL_ENABLE] = 1'b0;
            end
        end
    end

    // Control and counter registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            control_r <= `CTL_RESET;
            repeat_r <= `RPT_RESET;
        end else begin
            control_r <= control_nxt;
            repeat_r <= repeat_nxt;
        end
    end

    // ----------------------------------------
    // Avalon-MM slave
    // ----------------------------------------
    // Acknowledge: write one cycle after request, read two cycles
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            rd_pending_r <= 1'b0;
            rd_index_r <= 4'h0;
        end else begin
            ack_r <= bus_wr || rd_pending_r;
            rd_pending_r <= bus_rd;
            if (bus_rd) begin
                rd_index_r <= word_idx;
            end
        end
    end

    // Wait request low only in the answer cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(bus_wr || rd_pending_r);
        end
    end

    // Read data mux, registered
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= `DATA_ZERO;
        end else if (rd_pending_r) begin
            if (rd_index_r == `OFS_CONTROL) begin
                avs_readdata <= {24'h00_0000, control_r};
            end else if (rd_index_r == `OFS_REPEAT) begin
                avs_readdata <= {24'h00_0000, repeat_r};
            end else if (rd_index_r == `OFS_STATUS) begin
                avs_readdata <= {31'h0000_0000, hit};
            end else if (value_slot(rd_index_r) != `SLOT_NONE) begin
                avs_readdata <= {24'h00_0000, mem_rd & value_mask(rd_index_r)};
            end else begin
                avs_readdata <= `DEAD_READ;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_last_disables: assert property (@(posedge clock) disable iff (!arst_n)
        (fire && repeat_r == `RPT_ZERO && !chime && !bus_wr) |=> !control_r[`CTL_ENABLE])
        else $error("enable not cleared after last alarm");

    a_count_down: assert property (@(posedge clock) disable iff (!arst_n)
        (fire && repeat_r != `RPT_ZERO && !bus_wr) |=> repeat_r == $past(repeat_r) - 8'h01)
        else $error("repeat counter did not decrement");

    a_chime_wrap: assert property (@(posedge clock) disable iff (!arst_n)
        (fire && repeat_r == `RPT_ZERO && chime && !bus_wr) |=> repeat_r == 8'hff)
        else $error("repeat counter did not wrap with chime");

    a_stop_zero: assert property (@(posedge clock) disable iff (!arst_n)
        (fire && repeat_r == `RPT_ZERO && !chime && !bus_wr) |=> repeat_r == `RPT_ZERO)
        else $error("repeat counter left zero without chime");

    a_event_cause: assert property (@(posedge clock) disable iff (!arst_n)
        alarm_event |-> $past(enable) && $past(hit))
        else $error("alarm event without enabled match");

    a_reserved_quiet: assert property (@(posedge clock) disable iff (!arst_n)
        (interval > `IVL_YEAR) ##1 (interval > `IVL_YEAR) |-> !hit)
        else $error("match on reserved interval");

    a_value_upper: assert property (@(posedge clock) disable iff (!arst_n)
        (rd_pending_r && value_slot(rd_index_r) != `SLOT_NONE) |=> (avs_readdata[31:8] == 24'h00_0000)
            && !avs_waitrequest)
        else $error("value read with upper bits set");

    a_write_answer: assert property (@(posedge clock) disable iff (!arst_n)
        bus_wr |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("write not answered in one cycle");

    a_read_answer: assert property (@(posedge clock) disable iff (!arst_n)
        bus_rd |=> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered in two cycles");

    a_idle_wait: assert property (@(posedge clock) disable iff (!arst_n)
        (!bus_wr && !rd_pending_r) |=> avs_waitrequest)
        else $error("wait request dropped with no answer due");

    a_half_fires: assert property (@(posedge clock) disable iff (!arst_n)
        (enable && hit && interval == `IVL_HALFSEC && tick_half) |=> alarm_event)
        else $error("half second alarm missed");

    a_half_ignores: assert property (@(posedge clock) disable iff (!arst_n)
        (interval == `IVL_HALFSEC && !tick_half) |=> !alarm_event)
        else $error("half second alarm without half tick");

    a_second_fires: assert property (@(posedge clock) disable iff (!arst_n)
        (enable && hit && interval != `IVL_HALFSEC && tick_second) |=> alarm_event)
        else $error("matched alarm missed on second tick");

    a_disabled_quiet: assert property (@(posedge clock) disable iff (!arst_n)
        !enable |=> !alarm_event)
        else $error("alarm event while disabled");

    a_second_match: assert property (@(posedge clock) disable iff (!arst_n)
        (interval == `IVL_SECOND) ##1 (interval == `IVL_SECOND) |-> hit)
        else $error("every second interval not matching");

    a_tensec_match: assert property (@(posedge clock) disable iff (!arst_n)
        (interval == `IVL_TENSEC && now.second[3:0] == alarm_vals.second[3:0]) |=> hit)
        else $error("ten second interval missed units match");

    a_minute_miss: assert property (@(posedge clock) disable iff (!arst_n)
        (interval == `IVL_MINUTE && (now.second & `MASK_SECOND) != (alarm_vals.second & `MASK_SECOND)) |=> !hit)
        else $error("minute interval matched wrong second");

    a_year_miss: assert property (@(posedge clock) disable iff (!arst_n)
        (interval == `IVL_YEAR && (now.month & `MASK_MONTH) != (alarm_vals.month & `MASK_MONTH)) |=> !hit)
        else $error("yearly interval matched wrong month");

    a_chime_keeps: assert property (@(posedge clock) disable iff (!arst_n)
        (fire && chime && !bus_wr) |=> control_r[`CTL_ENABLE])
        else $error("enable lost with chime on");

    a_enable_hold: assert property (@(posedge clock) disable iff (!arst_n)
        (enable && !fire && !bus_wr) |=> enable)
        else $error("enable cleared without an event");

    a_repeat_hold: assert property (@(posedge clock) disable iff (!arst_n)
        (!fire && !bus_wr) |=> $stable(repeat_r))
        else $error("repeat counter moved without an event");

    a_repeat_write: assert property (@(posedge clock) disable iff (!arst_n)
        (bus_wr && avs_byteenable[0] && word_idx == `OFS_REPEAT && !fire) |=> repeat_r == $past(avs_writedata[7:0]))
        else $error("repeat counter write lost");

    a_ctl_write: assert property (@(posedge clock) disable iff (!arst_n)
        (bus_wr && avs_byteenable[0] && word_idx == `OFS_CONTROL && !fire)
            |=> interval == $past(avs_writedata[`CTL_MASK_HI:`CTL_MASK_LO]))
        else $error("interval write lost");
endmodule

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

module tb_top;
    import alarm_pkg::*;
    logic clock, arst_n, avs_read, avs_write, avs_waitrequest;
    logic tick_half, tick_second, alarm_event, tk_d;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    cal_time_t now, alm, t;
    logic [31:0] rd_q[$];
    logic ev_q[$];
    logic [7:0] rpt;
    int n_errors, checked, i;

    calendar_alarm_match DUT (
        .clock(clock),
        .arst_n(arst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .now(now),
        .tick_half(tick_half),
        .tick_second(tick_second),
        .alarm_event(alarm_event)
    );

    // Free running clock, 10 ns period
    always #5 clock = ~clock;

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task summarize;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    // ----------------------------------------
    // Bus and tick drivers
    // ----------------------------------------
    // Holds the request until waitrequest is seen low, then lets an edge pass
    task wait_ack;
        int k;
        k = 0;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) begin
            if (k == 40) begin
                n_errors++;
                summarize;
            end
            k++;
            @(posedge clock);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask

    task bus_write(input logic [3:0] idx, input logic [7:0] d, input logic [3:0] be);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack;
    endtask

    task bus_read(input logic [3:0] idx, input logic [31:0] exp);
        rd_q.push_back(exp);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        wait_ack;
    endtask

    task wr_rd(input logic [3:0] idx, input logic [7:0] d, input logic [31:0] exp);
        bus_write(idx, d, 4'h1);
        bus_read(idx, exp);
    endtask

    // Interval 0 runs on the half-second tick, all others on the second tick
    task tick(input int code, input logic exp);
        repeat (3) @(posedge clock);
        ev_q.push_back(exp);
        if (code == 0) begin
            tick_half <= 1'b1;
        end else begin
            tick_second <= 1'b1;
        end
        @(posedge clock);
        tick_half <= 1'b0;
        tick_second <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    function automatic logic [7:0] bcd(input int tmax);
        logic [3:0] tn, un;
        tn = 4'($urandom % (tmax + 1));
        un = 4'($urandom % 10);
        return {tn, un};
    endfunction

    // ----------------------------------------
    // Monitor: pops the oldest note as each result appears
    // ----------------------------------------
    always @(posedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (rd_q.size() == 0) begin
                chk(avs_readdata, 32'hffff_ffff);
            end else begin
                chk(avs_readdata, rd_q.pop_front());
            end
        end
        if (tk_d && ev_q.size() > 0) begin
            chk({31'h0000_0000, alarm_event}, {31'h0000_0000, ev_q.pop_front()});
        end else if (alarm_event === 1'b1) begin
            chk(32'h0000_0001, 32'h0000_0000);
        end
        tk_d = (tick_second === 1'b1) || (tick_half === 1'b1);
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        tick_half = 1'b0;
        tick_second = 1'b0;
        now = '0;
        tk_d = 1'b0;
        n_errors = 0;
        checked = 0;
        i = $urandom(2);
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        // Reset values and field widths
        bus_read(`OFS_CONTROL, 32'h0000_0000);
        bus_read(`OFS_REPEAT, 32'h0000_0000);
        wr_rd(`OFS_DAY, 8'hff, 32'h0000_003f);
        wr_rd(`OFS_HOUR, 8'hff, 32'h0000_003f);
        wr_rd(`OFS_MINUTE, 8'hff, 32'h0000_007f);
        wr_rd(`OFS_SECOND, 8'hff, 32'h0000_007f);
        wr_rd(`OFS_MONTH, 8'hff, 32'h0000_001f);
        wr_rd(`OFS_WEEKDAY, 8'hff, 32'h0000_0007);
        wr_rd(`OFS_CONTROL, 8'hff, 32'h0000_00fc);
        bus_read(4'hf, `DEAD_READ);
        bus_write(`OFS_DAY, 8'h12, 4'h0);
        bus_read(`OFS_DAY, 32'h0000_003f);
        // Random legal alarm values
        alm.month = bcd(1);
        alm.month[7:5] = 3'b000;
        alm.weekday = 8'($urandom % 7);
        alm.day = bcd(3);
        alm.hour = bcd(2);
        alm.minute = bcd(5);
        alm.second = bcd(5);
        wr_rd(`OFS_MONTH, alm.month, {24'h00_0000, alm.month});
        wr_rd(`OFS_WEEKDAY, alm.weekday, {24'h00_0000, alm.weekday});
        wr_rd(`OFS_DAY, alm.day, {24'h00_0000, alm.day});
        wr_rd(`OFS_HOUR, alm.hour, {24'h00_0000, alm.hour});
        wr_rd(`OFS_MINUTE, alm.minute, {24'h00_0000, alm.minute});
        wr_rd(`OFS_SECOND, alm.second, {24'h00_0000, alm.second});
        $display("test registers done");
        // Every interval code with a full match, then reserved codes
        now <= alm;
        rpt = 8'h20;
        bus_write(`OFS_REPEAT, rpt, 4'h1);
        for (i = 0; i < 16; i++) begin
            bus_write(`OFS_CONTROL, {2'b10, 4'(i), 2'b00}, 4'h1);
            tick(i, i < 10);
            if (i < 10) begin
                rpt = rpt - 8'h01;
            end
        end
        bus_read(`OFS_REPEAT, {24'h00_0000, rpt});
        $display("test intervals done");
        // Partial mismatches against the selected fields
        t = alm;
        t.second = alm.second ^ 8'h01;
        now <= t;
        bus_write(`OFS_CONTROL, 8'h8c, 4'h1);
        tick(3, 1'b0);
        bus_write(`OFS_CONTROL, 8'h84, 4'h1);
        tick(1, 1'b1);
        t = alm;
        t.month = alm.month ^ 8'h01;
        now <= t;
        bus_write(`OFS_CONTROL, 8'ha4, 4'h1);
        tick(9, 1'b0);
        bus_write(`OFS_CONTROL, 8'h9c, 4'h1);
        tick(7, 1'b1);
        rpt = rpt - 8'h02;
        bus_read(`OFS_REPEAT, {24'h00_0000, rpt});
        $display("test mismatch done");
        // Last event clears the enable, counter stays at zero
        now <= alm;
        bus_write(`OFS_REPEAT, 8'h00, 4'h1);
        bus_write(`OFS_CONTROL, 8'h84, 4'h1);
        tick(1, 1'b1);
        bus_read(`OFS_CONTROL, 32'h0000_0004);
        bus_read(`OFS_REPEAT, 32'h0000_0000);
        bus_read(`OFS_STATUS, 32'h0000_0001);
        tick(1, 1'b0);
        $display("test auto clear done");
        // Chime lets the counter wrap and keeps the enable
        bus_write(`OFS_CONTROL, 8'hc4, 4'h1);
        tick(1, 1'b1);
        bus_read(`OFS_REPEAT, 32'h0000_00ff);
        bus_read(`OFS_CONTROL, 32'h0000_00c4);
        tick(1, 1'b1);
        bus_read(`OFS_REPEAT, 32'h0000_00fe);
        $display("test chime done");
        // Reset in mid-run clears control and counter, keeps the values
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        bus_read(`OFS_CONTROL, 32'h0000_0000);
        bus_read(`OFS_REPEAT, 32'h0000_0000);
        bus_read(`OFS_DAY, {24'h00_0000, alm.day});
        bus_read(`OFS_STATUS, 32'h0000_0001);
        $display("test mid reset done");
        summarize;
    end
endmodule
`default_nettype wire
